// ===== core/pdr_pkg.sv
package pdr_pkg;

   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned NUM_REGS = 6;

   // Printed register indices; byte address is four times the index
   localparam logic [7:0] IDX_P3_PULLUP = 8'hE1;
   localparam logic [7:0] IDX_P5_PULLUP = 8'hE2;
   localparam logic [7:0] IDX_P6_PULLUP = 8'hE3;
   localparam logic [7:0] IDX_P1_DIR    = 8'hE4;
   localparam logic [7:0] IDX_P2_DIR    = 8'hE5;
   localparam logic [7:0] IDX_P3_DIR    = 8'hE6;

   localparam logic [ADDR_W-1:0] ADDR_P3_PULLUP = {2'h0, IDX_P3_PULLUP, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_P5_PULLUP = {2'h0, IDX_P5_PULLUP, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_P6_PULLUP = {2'h0, IDX_P6_PULLUP, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_P1_DIR    = {2'h0, IDX_P1_DIR, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_P2_DIR    = {2'h0, IDX_P2_DIR, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_P3_DIR    = {2'h0, IDX_P3_DIR, 2'h0};

   // Slot numbers of the register instances
   localparam int unsigned SLOT_P3_PULLUP = 0;
   localparam int unsigned SLOT_P5_PULLUP = 1;
   localparam int unsigned SLOT_P6_PULLUP = 2;
   localparam int unsigned SLOT_P1_DIR    = 3;
   localparam int unsigned SLOT_P2_DIR    = 4;
   localparam int unsigned SLOT_P3_DIR    = 5;

   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
   localparam logic [31:0]       READ_ZERO = 32'h0000_0000;
   localparam logic [NUM_REGS-1:0] NO_SLOT = 6'h00;

endpackage : pdr_pkg

// ===== core/pdr_port_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module pdr_port_ctrl (
   input  wire logic        clk_sys_in,
   input  wire logic        reset_n_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output var  logic [31:0] prdata_out,
   output var  logic        pready_out,
   output var  logic        pslverr_out,
   input  wire logic [7:0]  port5_direction_in,
   input  wire logic [7:0]  port6_direction_in,
   output var  logic [7:0]  port1_output_en_out,
   output var  logic [7:0]  port2_output_en_out,
   output var  logic [7:0]  port3_output_en_out,
   output var  logic [7:0]  port3_pullup_on_out,
   output var  logic [7:0]  port5_pullup_on_out,
   output var  logic [7:0]  port6_pullup_on_out
);

   ////////////////////////////////////////////////////////////////////////
   // Register storage

   pdr_wr_if wr_bus [pdr_pkg::NUM_REGS] ();

   // Slave side of the bus handshake
   typedef enum logic {
      PDR_APB_IDLE   = 1'b0,
      PDR_APB_ACCESS = 1'b1
   } pdr_apb_state_type;

   logic [pdr_pkg::NUM_REGS-1:0] slot_sel;
   logic                         addr_hit;
   logic                         setup_phase;
   logic                         write_fire;
   logic [pdr_pkg::DATA_W-1:0]   reg_val [pdr_pkg::NUM_REGS];
   logic [pdr_pkg::DATA_W-1:0]   read_byte;
   logic [31:0]                  prdata_d;
   logic [pdr_pkg::DATA_W-1:0]   port3_pullup_on_d;
   logic [pdr_pkg::DATA_W-1:0]   port5_pullup_on_d;
   logic [pdr_pkg::DATA_W-1:0]   port6_pullup_on_d;
   pdr_apb_state_type            apb_state_q;
   pdr_apb_state_type            apb_state_d;

   genvar gi;
   generate
      for (gi = 0; gi < pdr_pkg::NUM_REGS; gi++) begin : g_reg
         assign wr_bus[gi].wr_en = write_fire & slot_sel[gi];
         assign wr_bus[gi].wdata = pwdata_in[pdr_pkg::DATA_W-1:0];
         assign reg_val[gi]      = wr_bus[gi].value;
         pdr_reg8 u_reg (
            .clk_sys_in (clk_sys_in),
            .reset_n_in (reset_n_in),
            .wr_port    (wr_bus[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // APB decode

   always_comb begin
      slot_sel = pdr_pkg::NO_SLOT;
      if (paddr_in == pdr_pkg::ADDR_P3_PULLUP) begin
         slot_sel[pdr_pkg::SLOT_P3_PULLUP] = 1'b1;
      end else if (paddr_in == pdr_pkg::ADDR_P5_PULLUP) begin
         slot_sel[pdr_pkg::SLOT_P5_PULLUP] = 1'b1;
      end else if (paddr_in == pdr_pkg::ADDR_P6_PULLUP) begin
         slot_sel[pdr_pkg::SLOT_P6_PULLUP] = 1'b1;
      end else if (paddr_in == pdr_pkg::ADDR_P1_DIR) begin
         slot_sel[pdr_pkg::SLOT_P1_DIR] = 1'b1;
      end else if (paddr_in == pdr_pkg::ADDR_P2_DIR) begin
         slot_sel[pdr_pkg::SLOT_P2_DIR] = 1'b1;
      end else if (paddr_in == pdr_pkg::ADDR_P3_DIR) begin
         slot_sel[pdr_pkg::SLOT_P3_DIR] = 1'b1;
      end
   end

   assign addr_hit    = |slot_sel;
   assign setup_phase = psel_in & ~penable_in;
   // Only a mapped address in the completing access cycle writes
   assign write_fire  = psel_in & penable_in & pwrite_in & addr_hit
                        & (apb_state_q == PDR_APB_ACCESS);

   ////////////////////////////////////////////////////////////////////////
   // APB answer: one access cycle, no wait states

   always_comb begin
      apb_state_d = apb_state_q;
      case (apb_state_q)
         PDR_APB_IDLE: begin
            if (setup_phase) begin
               apb_state_d = PDR_APB_ACCESS;
            end
         end
         PDR_APB_ACCESS: begin
            if (setup_phase) begin
               apb_state_d = PDR_APB_ACCESS;
            end else begin
               apb_state_d = PDR_APB_IDLE;
            end
         end
         default: begin
            apb_state_d = PDR_APB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         apb_state_q <= PDR_APB_IDLE;
      end else begin
         apb_state_q <= apb_state_d;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         pready_out <= 1'b0;
      end else begin
         pready_out <= (apb_state_d == PDR_APB_ACCESS);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         pslverr_out <= 1'b0;
      end else begin
         pslverr_out <= setup_phase & ~addr_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data

   always_comb begin
      read_byte = pdr_pkg::REG_RESET;
      if (slot_sel[pdr_pkg::SLOT_P3_PULLUP]) begin
         read_byte = reg_val[pdr_pkg::SLOT_P3_PULLUP];
      end else if (slot_sel[pdr_pkg::SLOT_P5_PULLUP]) begin
         read_byte = reg_val[pdr_pkg::SLOT_P5_PULLUP];
      end else if (slot_sel[pdr_pkg::SLOT_P6_PULLUP]) begin
         read_byte = reg_val[pdr_pkg::SLOT_P6_PULLUP];
      end else if (slot_sel[pdr_pkg::SLOT_P1_DIR]) begin
         read_byte = pdr_pkg::REG_RESET;
      end else if (slot_sel[pdr_pkg::SLOT_P2_DIR]) begin
         read_byte = pdr_pkg::REG_RESET;
      end else if (slot_sel[pdr_pkg::SLOT_P3_DIR]) begin
         read_byte = pdr_pkg::REG_RESET;
      end
   end

   always_comb begin
      prdata_d = pdr_pkg::READ_ZERO;
      prdata_d[pdr_pkg::DATA_W-1:0] = read_byte;
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         prdata_out <= pdr_pkg::READ_ZERO;
      end else if (setup_phase & ~pwrite_in) begin
         prdata_out <= prdata_d;
      end else if (~psel_in) begin
         prdata_out <= pdr_pkg::READ_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin control outputs

   always_comb begin
      port3_pullup_on_d = reg_val[pdr_pkg::SLOT_P3_PULLUP]
                          & ~reg_val[pdr_pkg::SLOT_P3_DIR];
      port5_pullup_on_d = reg_val[pdr_pkg::SLOT_P5_PULLUP]
                          & ~port5_direction_in;
      port6_pullup_on_d = reg_val[pdr_pkg::SLOT_P6_PULLUP]
                          & ~port6_direction_in;
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         port1_output_en_out <= pdr_pkg::REG_RESET;
      end else begin
         port1_output_en_out <= reg_val[pdr_pkg::SLOT_P1_DIR];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         port2_output_en_out <= pdr_pkg::REG_RESET;
      end else begin
         port2_output_en_out <= reg_val[pdr_pkg::SLOT_P2_DIR];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         port3_output_en_out <= pdr_pkg::REG_RESET;
      end else begin
         port3_output_en_out <= reg_val[pdr_pkg::SLOT_P3_DIR];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         port3_pullup_on_out <= pdr_pkg::REG_RESET;
      end else begin
         port3_pullup_on_out <= port3_pullup_on_d;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         port5_pullup_on_out <= pdr_pkg::REG_RESET;
      end else begin
         port5_pullup_on_out <= port5_pullup_on_d;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         port6_pullup_on_out <= pdr_pkg::REG_RESET;
      end else begin
         port6_pullup_on_out <= port6_pullup_on_d;
      end
   end

endmodule // pdr_port_ctrl

`default_nettype wire

// ===== core/pdr_reg8.sv
`timescale 1ns/1ps
`default_nettype none

module pdr_reg8 (
   input  wire logic   clk_sys_in,
   input  wire logic   reset_n_in,
   pdr_wr_if.owner     wr_port
);

   logic [pdr_pkg::DATA_W-1:0] value_q;

   // Whole byte writable, cleared on reset
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         value_q <= pdr_pkg::REG_RESET;
      end else if (wr_port.wr_en) begin
         value_q <= wr_port.wdata;
      end
   end

   assign wr_port.value = value_q;

endmodule // pdr_reg8

`default_nettype wire

// ===== core/pdr_wr_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pdr_wr_if;
   logic                         wr_en;
   logic [pdr_pkg::DATA_W-1:0]   wdata;
   logic [pdr_pkg::DATA_W-1:0]   value;

   modport owner (input wr_en, input wdata, output value);
   modport user  (output wr_en, output wdata, input value);
endinterface : pdr_wr_if

`default_nettype wire

// ===== tb/pdr_port_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pdr_port_ctrl_monitor (
   input wire logic        clk_sys_in,
   input wire logic        reset_n_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic [7:0]  port5_direction_in,
   input wire logic [7:0]  port1_output_en_out,
   input wire logic [7:0]  port5_pullup_on_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   // Completed transfer to one address
   sequence done(a, w);
      psel_in && penable_in && pready_out && pwrite_in == w && paddr_in == a;
   endsequence
   chk_ready_after_setup: assert property (
      psel_in && !penable_in |=> pready_out) else $error("no ready");
   chk_dir_write_pin: assert property (
      done(pdr_pkg::ADDR_P1_DIR, 1'b1)
      |-> ##2 port1_output_en_out == $past(pwdata_in[7:0], 2))
      else $error("direction pin wrong");
   chk_dir_read_zero: assert property (
      done(pdr_pkg::ADDR_P1_DIR, 1'b0) |-> prdata_out == pdr_pkg::READ_ZERO)
      else $error("direction read not zero");
   chk_pullup_input_on: assert property (
      done(pdr_pkg::ADDR_P5_PULLUP, 1'b1) ##1 port5_direction_in == 8'h00
      |=> port5_pullup_on_out == $past(pwdata_in[7:0], 2))
      else $error("pull-up not applied");
   chk_pullup_output_off: assert property (
      (port5_pullup_on_out & $past(port5_direction_in)) == 8'h00)
      else $error("pull-up on output pin");
endmodule // pdr_port_ctrl_monitor
bind pdr_port_ctrl pdr_port_ctrl_monitor u_mon (.clk_sys_in, .reset_n_in,
   .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
   .pready_out, .port5_direction_in, .port1_output_en_out,
   .port5_pullup_on_out);
`default_nettype wire

// ===== tb/pdr_port_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pdr_port_ctrl_tb;
   logic        clk_sys_in, reset_n_in, psel_in, penable_in, pwrite_in;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, rd;
   logic        pready_out, pslverr_out, err;
   logic [7:0]  port5_direction_in, port6_direction_in;
   logic [7:0]  port1_output_en_out, port2_output_en_out, port3_output_en_out;
   logic [7:0]  port3_pullup_on_out, port5_pullup_on_out, port6_pullup_on_out;
   int          errors = 0, checks = 0;
   pdr_port_ctrl uut (.clk_sys_in, .reset_n_in, .psel_in, .penable_in,
      .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
      .pslverr_out, .port5_direction_in, .port6_direction_in,
      .port1_output_en_out, .port2_output_en_out, .port3_output_en_out,
      .port3_pullup_on_out, .port5_pullup_on_out, .port6_pullup_on_out);
   initial begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end
   ////////////////////////////////////////////////////////////////////////
   task cmp(input string name, input logic [31:0] e, s);
      checks++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", name, e, s);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'h2, w, a, d};
      @(posedge clk_sys_in);
      penable_in <= 1'b1;
      // Only the watchdog ends a hang
      do begin
         @(posedge clk_sys_in);
      end while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      {psel_in, penable_in} <= 2'h0;
   endtask
   task rd_chk(input string name, input logic [11:0] a, input logic [31:0] e,
               input logic ee);
      apb(1'b0, a, 32'h0);
      cmp(name, e, rd);
      cmp({name, "_err"}, {31'h0, ee}, {31'h0, err});
   endtask
   ////////////////////////////////////////////////////////////////////////
   task reset_values;
      rd_chk("p3_pull", pdr_pkg::ADDR_P3_PULLUP, 32'h0, 1'b0);
      rd_chk("p5_pull", pdr_pkg::ADDR_P5_PULLUP, 32'h0, 1'b0);
      rd_chk("p6_pull", pdr_pkg::ADDR_P6_PULLUP, 32'h0, 1'b0);
      rd_chk("unmapped", 12'h000, 32'h0, 1'b1);
      cmp("dirs", 32'h0, {8'h0, port1_output_en_out, port2_output_en_out,
          port3_output_en_out});
   endtask
   task pullup_rw;
      apb(1'b1, pdr_pkg::ADDR_P3_PULLUP, 32'hFFFF_FF5A);
      apb(1'b1, pdr_pkg::ADDR_P5_PULLUP, 32'h0000_00A5);
      apb(1'b1, pdr_pkg::ADDR_P6_PULLUP, 32'h1234_56C3);
      rd_chk("p3_pull", pdr_pkg::ADDR_P3_PULLUP, 32'h5A, 1'b0);
      rd_chk("p5_pull", pdr_pkg::ADDR_P5_PULLUP, 32'hA5, 1'b0);
      rd_chk("p6_pull", pdr_pkg::ADDR_P6_PULLUP, 32'hC3, 1'b0);
      cmp("pull_on", 32'h005AA5C3, {8'h0, port3_pullup_on_out,
          port5_pullup_on_out, port6_pullup_on_out});
   endtask
   task dir_gating;
      apb(1'b1, pdr_pkg::ADDR_P3_DIR, 32'h0000_00F0);
      port5_direction_in <= 8'h0F;
      port6_direction_in <= 8'hFF;
      repeat (2) @(posedge clk_sys_in);
      cmp("out_en3", 32'hF0, {24'h0, port3_output_en_out});
      cmp("pull_gate", 32'h000AA000, {8'h0, port3_pullup_on_out,
          port5_pullup_on_out, port6_pullup_on_out});
   endtask
   task dir_write_only;
      apb(1'b1, pdr_pkg::ADDR_P1_DIR, 32'hFFFF_FF81);
      apb(1'b1, pdr_pkg::ADDR_P2_DIR, 32'h0000_0042);
      rd_chk("p1_dir", pdr_pkg::ADDR_P1_DIR, 32'h0, 1'b0);
      cmp("out_en12", 32'h8142, {16'h0, port1_output_en_out,
          port2_output_en_out});
   endtask
   task complete_run;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      {reset_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
      {port5_direction_in, port6_direction_in} = 16'h0;
      repeat (10) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      reset_values;
      pullup_rw;
      dir_gating;
      dir_write_only;
      complete_run;
   end
   initial begin
      #20000;
      errors++;
      complete_run;
   end
endmodule // pdr_port_ctrl_tb
`default_nettype wire
